// *** src/pin_power_down_control_regs.svh ***
// Purpose: timing constants for the pin power-down control block
// Assumes: 50 MHz clock
// Notes:   times kept in their printed units, counts derived
`ifndef PIN_POWER_DOWN_CONTROL_REGS_SVH
`define PIN_POWER_DOWN_CONTROL_REGS_SVH
`define CLOCK_HZ          50000000
`define ENTRY_SETUP_NS    15
`define ENTRY_DONTCARE_NS 25
`define EXIT_VALID_US     1
`define CYC_PER_US        (`CLOCK_HZ / 1000000)
// least time rounds up
`define ENTRY_SETUP_CYC   ((`ENTRY_SETUP_NS * `CYC_PER_US + 999) / 1000)
// longest time rounds down
`define ENTRY_DONTCARE_CYC ((`ENTRY_DONTCARE_NS * `CYC_PER_US) / 1000)
`define EXIT_VALID_CYC    (`EXIT_VALID_US * `CYC_PER_US)
// fixed settle inside the wake window, and the input sync depth
`define WAKE_SETTLE_CYC   2
`define SYNC_STAGES       2
`endif

// *** src/pin_power_down_control_pkg.sv ***
// Purpose: types for the pin power-down control block
// Assumes: nothing
// Notes:   state encoding only
package pin_power_down_control_pkg;
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE  = 2'b10
  } pd_state_t;
endpackage : pin_power_down_control_pkg

// *** src/pin_power_down_control.sv ***
// Purpose: pin-controlled power-down hold of user pins and state
// Assumes: user logic on the same clock, pins synchronised here
// Notes:   freeze is one enable that the user core must honour
// How it works
// - feature enable chosen at build time
// - pin high sleeps, low runs
// - outputs and core state frozen
// - tristated outputs stay tristated
// - inputs except sleep pin blocked
// - hold latches keep last pin level
// - sleep pin never reaches user logic
// - inputs are don't-care after entry
// - wake within one microsecond
`timescale 1ns/1ps
`default_nettype none
`include "pin_power_down_control_regs.svh"

// two stages: levels from pins have no relation to the clock
module level_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  generate
    if (W < 1)
    begin : g_bad_w
      $error("level_sync: W below one");
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end

  assign q = s2_q;
endmodule : level_sync

// register that takes a new value only while the block runs
module hold_reg #(
  parameter int unsigned W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] value_q;

  generate
    if (W < 1)
    begin : g_bad_w
      $error("hold_reg: W below one");
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    if (rst)
      value_q <= '0;
    else if (load)
      value_q <= d;
  end

  assign q = value_q;
endmodule : hold_reg

module pin_power_down_control #(
  parameter bit          ENABLE   = 1'h1,
  parameter int unsigned WIDTH    = 8,
  parameter int unsigned WAKE_CYC = `EXIT_VALID_CYC
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             sleep_request_pin,
  input  wire logic [WIDTH-1:0] pin_in,
  input  wire logic [WIDTH-1:0] core_out,
  input  wire logic [WIDTH-1:0] core_oe,
  output logic      [WIDTH-1:0] core_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe,
  output logic                  core_freeze,
  output logic                  asleep
);
  // worst case from pin fall to live pins: sync, exit, settle, load
  localparam int unsigned SETTLE   = `WAKE_SETTLE_CYC;
  localparam int unsigned WAKE_LAT = `SYNC_STAGES + SETTLE + 2;
  localparam int unsigned CW       = $clog2(SETTLE + 1);

  generate
    if (WIDTH < 1)
    begin : g_bad_width
      $error("pin_power_down_control: WIDTH below one");
    end
    // WAKE_CYC is the budget the fixed wake must fit, capped at 1 us
    if (WAKE_CYC < WAKE_LAT || WAKE_CYC > `EXIT_VALID_CYC)
    begin : g_bad_wake
      $error("pin_power_down_control: wake budget out of range");
    end
  endgenerate

  pin_power_down_control_pkg::pd_state_t state_q;
  logic [CW-1:0]    wake_cnt_q;
  logic             req_sync;
  logic [WIDTH-1:0] pin_sync;
  logic             req;
  logic             run;
  logic             settle_done;

  // pins and request share one sync depth, so entry cuts cleanly
  level_sync #(
    .W (1)
  ) u_req_sync (
    .clock (clock),
    .rst   (rst),
    .d     (sleep_request_pin),
    .q     (req_sync)
  );

  level_sync #(
    .W (WIDTH)
  ) u_pin_sync (
    .clock (clock),
    .rst   (rst),
    .d     (pin_in),
    .q     (pin_sync)
  );

  // hold latches: capture only while running, keep level otherwise
  hold_reg #(
    .W (WIDTH)
  ) u_in_hold (
    .clock (clock),
    .rst   (rst),
    .load  (run),
    .d     (pin_sync),
    .q     (core_in)
  );

  hold_reg #(
    .W (WIDTH)
  ) u_out_hold (
    .clock (clock),
    .rst   (rst),
    .load  (run),
    .d     (core_out),
    .q     (pin_out)
  );

  // enables freeze too, so drivers off at entry stay off
  hold_reg #(
    .W (WIDTH)
  ) u_oe_hold (
    .clock (clock),
    .rst   (rst),
    .load  (run),
    .d     (core_oe),
    .q     (pin_oe)
  );

  // option off: pin is ignored entirely
  assign req = ENABLE & req_sync;

  // stop loading the very cycle the request is seen
  assign run = (state_q == pin_power_down_control_pkg::ST_RUN) && !req;
  assign settle_done = (wake_cnt_q == CW'(SETTLE - 1));

  // wake does not pass through reset: resume from what was held
  always_ff @(posedge clock)
  begin
    if (rst)
      state_q <= pin_power_down_control_pkg::ST_RUN;
    else
    begin
      case (state_q)
        pin_power_down_control_pkg::ST_RUN:
        begin
          if (req)
            state_q <= pin_power_down_control_pkg::ST_SLEEP;
        end
        pin_power_down_control_pkg::ST_SLEEP:
        begin
          if (!req)
            state_q <= pin_power_down_control_pkg::ST_WAKE;
        end
        pin_power_down_control_pkg::ST_WAKE:
        begin
          if (req)
            state_q <= pin_power_down_control_pkg::ST_SLEEP;
          else if (settle_done)
            state_q <= pin_power_down_control_pkg::ST_RUN;
        end
        default:
          state_q <= pin_power_down_control_pkg::ST_RUN;
      endcase
    end
  end

  // short fixed wake, well inside the allowed window
  always_ff @(posedge clock)
  begin
    if (rst)
      wake_cnt_q <= '0;
    else if (state_q != pin_power_down_control_pkg::ST_WAKE)
      wake_cnt_q <= '0;
    else if (!settle_done)
      wake_cnt_q <= wake_cnt_q + CW'(1);
  end

  // freeze as soon as the request is seen
  assign core_freeze = req | !(state_q == pin_power_down_control_pkg::ST_RUN);
  assign asleep      = (state_q == pin_power_down_control_pkg::ST_SLEEP);
endmodule : pin_power_down_control
`default_nettype wire

// *** test/nap_checker.sv ***
// Purpose: concurrent checks on the pin power-down control ports
// Assumes: bound into every instance, on its clock and rst
// Notes:   all bounds are a few cycles, far under the wake window
`timescale 1ns/1ps
`default_nettype none
module nap_checker #(
  parameter bit          ENABLE = 1'h1,
  parameter int unsigned WIDTH  = 8
) (
  input wire logic             clock,
  input wire logic             rst,
  input wire logic             sleep_request_pin,
  input wire logic             core_freeze,
  input wire logic             asleep,
  input wire logic [WIDTH-1:0] core_in,
  input wire logic [WIDTH-1:0] pin_out,
  input wire logic [WIDTH-1:0] pin_oe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // pin seen two edges late, state one edge after that
  property p_nap;
    (ENABLE && sleep_request_pin) [*6] |-> asleep;
  endproperty
  property p_run;
    (!sleep_request_pin) [*5] |-> !asleep;
  endproperty
  property p_stop;
    (ENABLE && sleep_request_pin) [*5] |-> core_freeze;
  endproperty
  property p_wake;
    (!sleep_request_pin) [*7] |-> !core_freeze;
  endproperty
  property p_off;
    !ENABLE |-> (!core_freeze && !asleep);
  endproperty

  AST_NAP: assert property (p_nap)
    else $error("asleep missing after a long sleep request");
  AST_RUN: assert property (p_run)
    else $error("asleep still high after the request ended");
  AST_STOP: assert property (p_stop)
    else $error("freeze missing during a sleep request");
  AST_WAKE: assert property (p_wake)
    else $error("freeze still high after the wake time");
  AST_HELD: assert property (asleep |-> core_freeze)
    else $error("asleep without freeze");
  AST_OUT: assert property ($past(core_freeze) |-> $stable(pin_out))
    else $error("pin data moved while frozen");
  AST_OE: assert property ($past(core_freeze) |-> $stable(pin_oe))
    else $error("pin enable moved while frozen");
  AST_IN: assert property ($past(core_freeze) |-> $stable(core_in))
    else $error("held input moved while frozen");
  AST_OFF: assert property (p_off)
    else $error("sleep reacted with the option off");

  C_SLEEP: cover property ($rose(asleep));
  C_WAKE: cover property ($fell(asleep));
  C_RESUME: cover property ($fell(core_freeze));
endmodule : nap_checker
`default_nettype wire

// *** test/nap_host.sv ***
// Purpose: model of the system driving the sleep pin and user pins
// Assumes: drives on the falling edge of the block clock
// Notes:   pins move only once the don't-care time has passed
`timescale 1ns/1ps
`default_nettype none
module nap_host (
  input  wire logic       clock,
  output var  logic       sleep_request_pin = 1'h0,
  output var  logic [7:0] pin_in            = 8'h3c
);
  // pins stay put through entry, then change while they are ignored
  task nap(input logic on, input logic [7:0] v);
    @(negedge clock);
    sleep_request_pin = on;
    repeat (3) @(negedge clock);
    pin_in = v;
  endtask : nap
endmodule : nap_host
`default_nettype wire

// *** test/test_pin_power_down_control.sv ***
// Purpose: bench for the pin power-down control block
// Assumes: 50 MHz clock, inputs driven on the falling edge
// Notes:   sleep and wake with the option on, one sleep with it off
`timescale 1ns/1ps
`default_nettype none
module test_pin_power_down_control;
  logic       clock    = 1'h0;
  logic       rst      = 1'h1;
  logic [7:0] core_out = 8'ha5;
  logic [7:0] core_oe  = 8'h0f;
  logic       sleep_request_pin;
  logic [7:0] pin_in;
  logic [7:0] core_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic       core_freeze;
  logic       asleep;
  logic [7:0] off_in;
  logic [7:0] off_out;
  logic [7:0] off_oe;
  logic       off_freeze;
  logic       off_asleep;
  int         err_count   = 0;
  int         check_count = 0;

  always #10 clock = ~clock;

  pin_power_down_control dut (
    .clock             (clock),
    .rst               (rst),
    .sleep_request_pin (sleep_request_pin),
    .pin_in            (pin_in),
    .core_out          (core_out),
    .core_oe           (core_oe),
    .core_in           (core_in),
    .pin_out           (pin_out),
    .pin_oe            (pin_oe),
    .core_freeze       (core_freeze),
    .asleep            (asleep)
  );

  // option off: the pin must change nothing
  pin_power_down_control #(
    .ENABLE (1'h0)
  ) dut_off (
    .clock             (clock),
    .rst               (rst),
    .sleep_request_pin (sleep_request_pin),
    .pin_in            (pin_in),
    .core_out          (core_out),
    .core_oe           (core_oe),
    .core_in           (off_in),
    .pin_out           (off_out),
    .pin_oe            (off_oe),
    .core_freeze       (off_freeze),
    .asleep            (off_asleep)
  );

  nap_host host (
    .clock             (clock),
    .sleep_request_pin (sleep_request_pin),
    .pin_in            (pin_in)
  );

  task check(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t %h %h", $time, seen, exp);
    end
  endtask : check

  task test_done(input bit late);
    err_count += late;
    if (err_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  task t_sleep;
    host.nap(1'h1, 8'hc3);
    {core_out, core_oe} = 16'h5af0;
    repeat (6) @(negedge clock);
    check({pin_out, pin_oe, core_in}, 24'ha50f3c);
    check({22'h0, core_freeze, asleep}, 24'h000003);
    check({off_out, off_oe, off_in}, 24'h5af0c3);
    check({22'h0, off_freeze, off_asleep}, 24'h000000);
  endtask : t_sleep

  task t_wake;
    host.nap(1'h0, 8'h99);
    repeat (4) @(negedge clock);
    check({pin_out, pin_oe, core_in}, 24'h5af099);
    check({22'h0, core_freeze, asleep}, 24'h000000);
  endtask : t_wake

  initial
  begin
    repeat (10) @(posedge clock);
    @(negedge clock);
    check({pin_out, pin_oe, core_in}, 24'h000000);
    check({22'h0, core_freeze, asleep}, 24'h000000);
    rst = 1'h0;
    // inputs need two sync edges and one load edge after release
    repeat (4) @(negedge clock);
    check({pin_out, pin_oe, core_in}, 24'ha50f3c);
    t_sleep;
    t_wake;
    test_done(1'h0);
  end

  // the tests need about thirty-three cycles; a hang ends here
  initial
  begin
    repeat (500) @(posedge clock);
    test_done(1'h1);
  end
endmodule : test_pin_power_down_control

bind pin_power_down_control nap_checker #(
  .ENABLE (ENABLE),
  .WIDTH  (WIDTH)
) chk (
  .clock             (clock),
  .rst               (rst),
  .sleep_request_pin (sleep_request_pin),
  .core_freeze       (core_freeze),
  .asleep            (asleep),
  .core_in           (core_in),
  .pin_out           (pin_out),
  .pin_oe            (pin_oe)
);
`default_nettype wire
